// file: core/vcz_defines.vh
/*
  register offsets, field positions, reset values and fixed codes
  for the default channel register slice.
  assumes a 12-bit byte address and 32-bit AXI4-Lite data words.
*/
`ifndef VCZ_DEFINES_VH
`define VCZ_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VCZ_OFF_PORT_STAT 12'h14C
`define VCZ_OFF_CAP 12'h150
`define VCZ_OFF_CTRL 12'h154
`define VCZ_OFF_STAT 12'h158
`define VCZ_OFF_CHAN_TBL 12'h180
`define VCZ_OFF_PORT_TBL 12'h1C0
`define VCZ_MASK_CHAN_TBL 12'hFF0
`define VCZ_MASK_PORT_TBL 12'hFC0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VCZ_BIT_LOAD_CHAN 0
`define VCZ_BIT_CHAN_TBL_STAT 16
`define VCZ_BIT_LOAD_PORT 16
`define VCZ_SEL_HI 19
`define VCZ_SEL_LO 17
`define VCZ_BIT_EN 31
`define VCZ_BIT_PORT_TBL_STAT 16
`define VCZ_BIT_NEG_PEND 17
`define VCZ_MAP_HI 7
`define VCZ_MAP_LO 0

// ----------------------------------------------------------------
// fixed and reset values
// ----------------------------------------------------------------
`define VCZ_CAP_ARB 8'h09
`define VCZ_RST_TS 7'h7F
`define VCZ_TBL_OFS 8'h04
`define VCZ_RST_MAP 8'hFF
`define VCZ_SEL_DEF 3'h0
`define VCZ_SEL_WRR 3'h3
`define VCZ_CHAN_ID 3'h0
`define VCZ_RST_EN 1'h1
`define VCZ_AS_ONLY 1'h0
`define VCZ_REJ_SNOOP 1'h0
`define VCZ_RESP_OKAY 2'h0
`define VCZ_RESP_SLVERR 2'h2

`endif

// file: core/vcz_table_loader.v
/*
  arbitration table store: software-written staging words and the
  applied copy used by the arbiter, with a word-by-word load sequence.
  assumes writes and the load pulse come from logic on the same clock.
*/
`timescale 1ns/1ps

module vcz_table_loader #(
  parameter DEPTH = 16,
  parameter IW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [IW-1:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [3:0] wr_strb,
  input wire [IW-1:0] sw_idx,
  output wire [31:0] sw_data,
  input wire load,
  output reg busy,
  output reg done,
  input wire [IW-1:0] use_idx,
  output wire [31:0] use_data
);

  reg [31:0] staged [0:DEPTH-1];
  reg [31:0] applied [0:DEPTH-1];
  reg [IW-1:0] cnt;
  reg [31:0] merged;
  integer b;

  // ----------------------------------------------------------------
  // staging write with byte strobes
  // ----------------------------------------------------------------
  always @* begin
    merged = staged[wr_idx];
    for (b = 0; b < 4; b = b + 1) begin
      if (wr_strb[b]) begin
        merged[b*8 +: 8] = wr_data[b*8 +: 8];
      end
    end
  end

  always @(posedge aclk) begin
    if (wr_en) begin
      staged[wr_idx] <= merged;
    end
    if (busy) begin
      applied[cnt] <= staged[cnt];
    end
  end

  // ----------------------------------------------------------------
  // load sequence, one word per cycle
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'h0;
      done <= 1'h0;
      cnt <= {IW{1'h0}};
    end else begin
      done <= 1'h0;
      if (busy) begin
        if (cnt == DEPTH[IW-1:0] - 1'h1) begin
          busy <= 1'h0;
          done <= 1'h1;
          cnt <= {IW{1'h0}};
        end else begin
          cnt <= cnt + 1'h1;
        end
      end else if (load) begin
        busy <= 1'h1;
      end
    end
  end

  assign sw_data = staged[sw_idx];
  assign use_data = applied[use_idx];

endmodule

// file: core/vcz_regs.v
/*
  default channel register slice behind an AXI4-Lite slave: port
  status, channel 0 capability, control and status words, plus the
  channel and port arbitration table stores.
  assumes EEPROM load strobes come from logic on aclk; the
  negotiation pending level may come from another domain.
*/
// Contract
// - Any software write to the channel arbitration table sets the channel table status flag.
// - The channel table status flag clears when the channel table load finishes.
// - The arbitration capability advertises round robin and 128-phase weighted round robin.
// - Time-based weighted round robin is never advertised or accepted on channel 0.
// - Maximum time slots reads 7Fh after reset and may be replaced by EEPROM load.
// - The packet-switching-only and reject-snoop capability bits read zero.
// - The port arbitration table offset field reads 04h in sixteen_byte_unit steps.
// - Each traffic-class map bit maps that class to channel 0, resets to FFh, EEPROM may load it.
// - Writing one to load-port-table starts the port table load and the bit reads zero.
// - Port arbitration select keeps 000b or 011b, any other value becomes 000b.
// - The channel identifier field reads 000b.
// - The channel enable bit resets to one and drives the vc_enable output.
// - Port table writes set the port table status flag; the finished load clears it.
// - Negotiation pending follows the negotiation state and resets to zero.
// - Writing one to load-channel-table starts the channel table load and the bit reads zero.
`timescale 1ns/1ps
`include "vcz_defines.vh"

module vcz_regs #(
  parameter AW = 12,
  parameter CHAN_DEPTH = 4,
  parameter CHAN_IW = 2,
  parameter PORT_DEPTH = 16,
  parameter PORT_IW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire eeprom_load,
  input wire [6:0] eeprom_time_slots,
  input wire [7:0] eeprom_tc_map,
  input wire negotiation_pending_in,
  output reg [7:0] tc_map,
  output reg [2:0] port_arb_sel,
  output reg vc_enable,
  output wire chan_tbl_busy,
  output wire port_tbl_busy,
  input wire [CHAN_IW-1:0] chan_use_idx,
  output wire [31:0] chan_use_data,
  input wire [PORT_IW-1:0] port_use_idx,
  output wire [31:0] port_use_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [AW-1:0] word_addr;
    input [AW-1:0] a;
    begin
      word_addr = {a[AW-1:2], 2'h0};
    end
  endfunction

  function is_chan_tbl;
    input [AW-1:0] a;
    begin
      is_chan_tbl = ((a & `VCZ_MASK_CHAN_TBL) == `VCZ_OFF_CHAN_TBL);
    end
  endfunction

  function is_port_tbl;
    input [AW-1:0] a;
    begin
      is_port_tbl = ((a & `VCZ_MASK_PORT_TBL) == `VCZ_OFF_PORT_TBL);
    end
  endfunction

  function is_mapped;
    input [AW-1:0] a;
    begin
      is_mapped = (word_addr(a) == `VCZ_OFF_PORT_STAT) ||
                  (word_addr(a) == `VCZ_OFF_CAP) ||
                  (word_addr(a) == `VCZ_OFF_CTRL) ||
                  (word_addr(a) == `VCZ_OFF_STAT) ||
                  is_chan_tbl(a) || is_port_tbl(a);
    end
  endfunction

  function [2:0] legal_sel;
    input [2:0] s;
    begin
      if (s == `VCZ_SEL_WRR) begin
        legal_sel = `VCZ_SEL_WRR;
      end else begin
        legal_sel = `VCZ_SEL_DEF;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  reg aw_held;
  reg [AW-1:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire write_fire;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      aw_addr <= {AW{1'h0}};
      w_held <= 1'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `VCZ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'h1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'h1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_fire) begin
        aw_held <= 1'h0;
        w_held <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= is_mapped(aw_addr) ? `VCZ_RESP_OKAY : `VCZ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_ctrl = write_fire && (word_addr(aw_addr) == `VCZ_OFF_CTRL);
  wire wr_port_ctrl = write_fire && (word_addr(aw_addr) == `VCZ_OFF_PORT_STAT);
  wire chan_tbl_wr = write_fire && is_chan_tbl(aw_addr);
  wire port_tbl_wr = write_fire && is_port_tbl(aw_addr);
  wire chan_load = wr_port_ctrl && w_strb[0] && w_data[`VCZ_BIT_LOAD_CHAN];
  wire port_load = wr_ctrl && w_strb[2] && w_data[`VCZ_BIT_LOAD_PORT];
  wire chan_done;
  wire port_done;
  wire [31:0] chan_sw_data;
  wire [31:0] port_sw_data;

  // ----------------------------------------------------------------
  // control word and loadable capability field
  // ----------------------------------------------------------------
  reg [6:0] time_slots;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tc_map <= `VCZ_RST_MAP;
      port_arb_sel <= `VCZ_SEL_DEF;
      vc_enable <= `VCZ_RST_EN;
      time_slots <= `VCZ_RST_TS;
    end else begin
      if (eeprom_load) begin
        time_slots <= eeprom_time_slots;
        tc_map <= eeprom_tc_map;
      end
      if (wr_ctrl) begin
        if (w_strb[0]) begin
          tc_map <= w_data[`VCZ_MAP_HI:`VCZ_MAP_LO];
        end
        if (w_strb[2]) begin
          port_arb_sel <= legal_sel(w_data[`VCZ_SEL_HI:`VCZ_SEL_LO]);
        end
        if (w_strb[3]) begin
          vc_enable <= w_data[`VCZ_BIT_EN];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // table status flags, set wins over clear
  // ----------------------------------------------------------------
  reg chan_tbl_stat;
  reg port_tbl_stat;

  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_tbl_stat <= 1'h0;
      port_tbl_stat <= 1'h0;
    end else begin
      chan_tbl_stat <= chan_tbl_wr || (chan_tbl_stat && !chan_done);
      port_tbl_stat <= port_tbl_wr || (port_tbl_stat && !port_done);
    end
  end

  // ----------------------------------------------------------------
  // negotiation pending synchroniser
  // ----------------------------------------------------------------
  reg neg_meta;
  reg neg_pending;

  always @(posedge aclk) begin
    if (!aresetn) begin
      neg_meta <= 1'h0;
      neg_pending <= 1'h0;
    end else begin
      neg_meta <= negotiation_pending_in;
      neg_pending <= neg_meta;
    end
  end

  // ----------------------------------------------------------------
  // table stores
  // ----------------------------------------------------------------
  vcz_table_loader #(
    .DEPTH(CHAN_DEPTH),
    .IW(CHAN_IW)
  ) u_chan_tbl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(chan_tbl_wr),
    .wr_idx(aw_addr[CHAN_IW+1:2]),
    .wr_data(w_data),
    .wr_strb(w_strb),
    .sw_idx(s_axi_araddr[CHAN_IW+1:2]),
    .sw_data(chan_sw_data),
    .load(chan_load),
    .busy(chan_tbl_busy),
    .done(chan_done),
    .use_idx(chan_use_idx),
    .use_data(chan_use_data)
  );

  vcz_table_loader #(
    .DEPTH(PORT_DEPTH),
    .IW(PORT_IW)
  ) u_port_tbl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(port_tbl_wr),
    .wr_idx(aw_addr[PORT_IW+1:2]),
    .wr_data(w_data),
    .wr_strb(w_strb),
    .sw_idx(s_axi_araddr[PORT_IW+1:2]),
    .sw_data(port_sw_data),
    .load(port_load),
    .busy(port_tbl_busy),
    .done(port_done),
    .use_idx(port_use_idx),
    .use_data(port_use_data)
  );

  // ----------------------------------------------------------------
  // read word assembly
  // ----------------------------------------------------------------
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0;
    case (word_addr(s_axi_araddr))
      `VCZ_OFF_PORT_STAT: begin
        rd_word[`VCZ_BIT_CHAN_TBL_STAT] = chan_tbl_stat;
        rd_word[`VCZ_BIT_LOAD_CHAN] = 1'h0;
      end
      `VCZ_OFF_CAP: begin
        rd_word = {`VCZ_TBL_OFS, 1'h0, time_slots,
                   `VCZ_REJ_SNOOP, `VCZ_AS_ONLY, 6'h0, `VCZ_CAP_ARB};
      end
      `VCZ_OFF_CTRL: begin
        rd_word = {vc_enable, 4'h0, `VCZ_CHAN_ID, 4'h0,
                   port_arb_sel, 1'h0, 8'h0, tc_map};
      end
      `VCZ_OFF_STAT: begin
        rd_word[`VCZ_BIT_PORT_TBL_STAT] = port_tbl_stat;
        rd_word[`VCZ_BIT_NEG_PEND] = neg_pending;
      end
      default: begin
        if (is_chan_tbl(s_axi_araddr)) begin
          rd_word = chan_sw_data;
        end else if (is_port_tbl(s_axi_araddr)) begin
          rd_word = port_sw_data;
        end else begin
          rd_word = 32'h0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `VCZ_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `VCZ_RESP_OKAY : `VCZ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

endmodule

// file: tb/vcz_regs_asserts.sv
/*
  checker for the default channel register slice.
  assumes it is bound to vcz_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module vcz_regs_chk #(
  parameter AW = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [7:0] tc_map,
  input wire [2:0] port_arb_sel,
  input wire vc_enable,
  input wire chan_tbl_busy,
  input wire port_tbl_busy
);
  // ----
  // properties
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  AST_RST_VAL: assert property (
    $rose(aresetn) |-> tc_map == 8'hFF && vc_enable && port_arb_sel == 3'h0)
    else $error("control word not at reset values");
  AST_CAP_RD: assert property (
    ar_hs && s_axi_araddr == 12'h150 |=>
      s_axi_rdata[31:23] == 9'h008 && s_axi_rdata[15:0] == 16'h0009)
    else $error("capability word fixed fields wrong");
  AST_CTRL_RD: assert property (
    ar_hs && s_axi_araddr == 12'h154 |=> s_axi_rdata[30:20] == 11'h000 &&
      s_axi_rdata[16:8] == 9'h000 && s_axi_rdata[19:17] == $past(port_arb_sel) &&
      s_axi_rdata[31] == $past(vc_enable) && s_axi_rdata[7:0] == $past(tc_map))
    else $error("control word read mismatch");
  AST_STAT_RD: assert property (
    ar_hs && s_axi_araddr == 12'h158 |=>
      s_axi_rdata[31:18] == 14'h0000 && s_axi_rdata[15:0] == 16'h0000)
    else $error("status word reserved bits set");
  AST_PSTAT_RD: assert property (
    ar_hs && s_axi_araddr == 12'h14C |=>
      s_axi_rdata[31:17] == 15'h0000 && s_axi_rdata[15:0] == 16'h0000)
    else $error("port status word reserved or load bit set");
  AST_SEL_LEGAL: assert property (
    port_arb_sel == 3'h0 || port_arb_sel == 3'h3)
    else $error("illegal port arbitration select");
  AST_PORT_LOAD: assert property (
    wr_hs && s_axi_awaddr == 12'h154 && s_axi_wstrb[2] && s_axi_wdata[16] &&
      !port_tbl_busy |-> ##[1:3] port_tbl_busy)
    else $error("port table load did not start");
  AST_CHAN_LOAD: assert property (
    wr_hs && s_axi_awaddr == 12'h14C && s_axi_wstrb[0] && s_axi_wdata[0] &&
      !chan_tbl_busy |-> ##[1:3] chan_tbl_busy)
    else $error("channel table load did not start");
  AST_PORT_DONE: assert property (
    $rose(port_tbl_busy) |-> ##[1:20] !port_tbl_busy)
    else $error("port table load never finished");
  AST_CHAN_DONE: assert property (
    $rose(chan_tbl_busy) |-> ##[1:8] !chan_tbl_busy)
    else $error("channel table load never finished");
endmodule

bind vcz_regs vcz_regs_chk #(.AW(AW)) chk_u (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .tc_map, .port_arb_sel, .vc_enable,
  .chan_tbl_busy, .port_tbl_busy
);

// file: tb/test_virtual_channel_zero_regs.sv
/*
  self-checking bench for the default channel register slice.
  assumes vcz_regs with default parameters and the bound checker.
*/
`timescale 1ns/1ps
module test_virtual_channel_zero_regs;
  // ----
  // signals
  // ----
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic ee_load = 1'h0;
  logic [6:0] ee_ts = 7'h00;
  logic [7:0] ee_map = 8'h00;
  logic neg_in = 1'h0;
  logic [1:0] cidx = 2'h0;
  logic [3:0] pidx = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, vc_en, cbusy, pbusy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, cdata, pdata;
  wire [7:0] tc_map;
  wire [2:0] sel;
  int num_errors = 0;
  int n_checks = 0;

  always #4 aclk = ~aclk;

  vcz_regs dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eeprom_load(ee_load), .eeprom_time_slots(ee_ts), .eeprom_tc_map(ee_map),
    .negotiation_pending_in(neg_in), .tc_map(tc_map), .port_arb_sel(sel),
    .vc_enable(vc_en), .chan_tbl_busy(cbusy), .port_tbl_busy(pbusy),
    .chan_use_idx(cidx), .chan_use_data(cdata), .port_use_idx(pidx),
    .port_use_data(pdata)
  );

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic wait_idle;
    do @(posedge aclk); while (cbusy || pbusy);
    repeat (2) @(posedge aclk);
  endtask

  task automatic summarize;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rd_chk(12'h14C, 32'h0, 2'h0);
    rd_chk(12'h150, 32'h047F0009, 2'h0);
    rd_chk(12'h154, 32'h800000FF, 2'h0);
    rd_chk(12'h158, 32'h0, 2'h0);
    chk({29'h0, sel}, 32'h0);
  endtask

  task automatic t_ctrl;
    wr(12'h154, 32'h7EF6FF5A, 4'hF, 2'h0);
    rd_chk(12'h154, 32'h0006005A, 2'h0);
    chk({24'h0, tc_map}, 32'h5A);
    chk({31'h0, vc_en}, 32'h0);
    wr(12'h154, 32'h80000000, 4'h8, 2'h0);
    rd_chk(12'h154, 32'h8006005A, 2'h0);
  endtask

  task automatic t_sel;
    for (int s = 0; s < 8; s++) begin
      wr(12'h154, 32'h800000FF | (32'(s) << 17), 4'hF, 2'h0);
      chk({29'h0, sel}, (s == 3) ? 32'h3 : 32'h0);
    end
  endtask

  task automatic t_port;
    pidx <= 4'h1;
    wr(12'h1C4, 32'hA5C30F1E, 4'hF, 2'h0);
    rd_chk(12'h1C4, 32'hA5C30F1E, 2'h0);
    rd_chk(12'h158, 32'h00010000, 2'h0);
    wr(12'h154, 32'h800100FF, 4'hF, 2'h0);
    rd_chk(12'h154, 32'h800000FF, 2'h0);
    wait_idle;
    rd_chk(12'h158, 32'h0, 2'h0);
    chk(pdata, 32'hA5C30F1E);
  endtask

  task automatic t_chan;
    cidx <= 2'h2;
    wr(12'h188, 32'h1234ABCD, 4'hF, 2'h0);
    wr(12'h188, 32'h5566FFFF, 4'hC, 2'h0);
    rd_chk(12'h188, 32'h5566ABCD, 2'h0);
    rd_chk(12'h14C, 32'h00010000, 2'h0);
    wr(12'h14C, 32'h00000001, 4'h1, 2'h0);
    wait_idle;
    rd_chk(12'h14C, 32'h0, 2'h0);
    chk(cdata, 32'h5566ABCD);
  endtask

  task automatic t_eeprom;
    ee_ts <= 7'h15;
    ee_map <= 8'h3C;
    ee_load <= 1'h1;
    @(posedge aclk);
    ee_load <= 1'h0;
    rd_chk(12'h150, 32'h04150009, 2'h0);
    chk({24'h0, tc_map}, 32'h3C);
  endtask

  task automatic t_neg;
    neg_in <= 1'h1;
    repeat (3) @(posedge aclk);
    rd_chk(12'h158, 32'h00020000, 2'h0);
    neg_in <= 1'h0;
    repeat (3) @(posedge aclk);
    rd_chk(12'h158, 32'h0, 2'h0);
  endtask

  task automatic t_bad;
    wr(12'h100, 32'hFFFFFFFF, 4'hF, 2'h2);
    rd_chk(12'h100, 32'h0, 2'h2);
    wr(12'h150, 32'h0, 4'hF, 2'h0);
    rd_chk(12'h150, 32'h04150009, 2'h0);
    wr(12'h158, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd_chk(12'h158, 32'h0, 2'h0);
  endtask

  task automatic t_rst;
    wr(12'h154, 32'h00060000, 4'hC, 2'h0);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(12'h150, 32'h047F0009, 2'h0);
    rd_chk(12'h154, 32'h800000FF, 2'h0);
    rd_chk(12'h14C, 32'h0, 2'h0);
    chk({29'h0, sel}, 32'h0);
  endtask

  // ----
  // run
  // ----
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_ctrl;
    t_sel;
    t_port;
    t_chan;
    t_eeprom;
    t_neg;
    t_bad;
    t_rst;
    summarize;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize;
  end
endmodule
